// [rtl/fdo_map.svh]
`ifndef FDO_MAP_SVH
`define FDO_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FDO_ADDR_UPPER_LO 12'h247
`define FDO_ADDR_UPPER_HI 12'h248
`define FDO_ADDR_LOWER_LO 12'h249
`define FDO_ADDR_LOWER_HI 12'h24A
`define FDO_ADDR_DWELL_LO 12'h24B
`define FDO_ADDR_DWELL_HI 12'h24C
`define FDO_ADDR_CTRL 12'h559
`define FDO_ADDR_OVR_CLR 12'h562
`define FDO_ADDR_OVR_STAT 12'h563

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FDO_CTRL_EN_A_BIT 0
`define FDO_CTRL_EN_B_BIT 1
`define FDO_CTRL_ALM_A_BIT 4
`define FDO_CTRL_ALM_B_BIT 5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FDO_RST_BYTE 8'h00
`define FDO_RST_DWELL_LO 8'h01

// ----------------------------------------------------------------------------
// Widths and timing counts (clock cycles)
// ----------------------------------------------------------------------------
`define FDO_SAMPLE_W 14
`define FDO_MAG_W 13
`define FDO_DWELL_W 16
`define FDO_NUM_VCONV 8
`define FDO_UPPER_LAT 28
`define FDO_DATA_LAT 32

`endif

// [rtl/fdo_pkg.sv]
`default_nettype none

`include "fdo_map.svh"

package fdo_pkg;

  typedef logic [`FDO_SAMPLE_W-1:0] fdo_sample_t;
  typedef logic [`FDO_MAG_W-1:0] fdo_mag_t;
  typedef logic [`FDO_DWELL_W-1:0] fdo_dwell_t;
  typedef logic [7:0] fdo_byte_t;

  // Full-scale negative has no positive twin, so it saturates to the top code.
  function automatic fdo_mag_t fdo_magnitude(input fdo_sample_t s);
    fdo_sample_t n;
    n = ~s + `FDO_SAMPLE_W'(1);
    if (!s[`FDO_SAMPLE_W-1]) begin
      return s[`FDO_MAG_W-1:0];
    end else if (n[`FDO_SAMPLE_W-1]) begin
      return {`FDO_MAG_W{1'b1}};
    end else begin
      return n[`FDO_MAG_W-1:0];
    end
  endfunction

endpackage : fdo_pkg

`default_nettype wire

// [rtl/fdo_chan_det.sv]
`default_nettype none

`include "fdo_map.svh"

module fdo_chan_det
  import fdo_pkg::*;
#(
  parameter int UPPER_LAT = `FDO_UPPER_LAT,
  parameter int DATA_LAT = `FDO_DATA_LAT
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable,
  input wire fdo_sample_t sample,
  input wire logic ovr_in,
  input wire fdo_mag_t upper_thr,
  input wire fdo_mag_t lower_thr,
  input wire fdo_dwell_t dwell,
  output logic alarm,
  output logic clip
);

  // --------------------------------------------------------------------------
  // Comparators
  // --------------------------------------------------------------------------
  fdo_mag_t mag;
  logic above_now;
  logic [UPPER_LAT-2:0] above_pipe_reg;
  fdo_mag_t mag_pipe_reg [DATA_LAT-1];
  logic [DATA_LAT-2:0] ovr_pipe_reg;
  fdo_dwell_t dwell_cnt_reg;
  fdo_dwell_t dwell_cnt_next;
  logic alarm_next;
  logic below;
  logic dwell_done;
  logic set_hit;

  assign mag = fdo_magnitude(sample);
  assign above_now = enable && (mag > upper_thr);
  assign below = mag_pipe_reg[DATA_LAT-2] < lower_thr;
  assign dwell_done = dwell_cnt_reg >= dwell;
  assign set_hit = above_pipe_reg[UPPER_LAT-2];

  // --------------------------------------------------------------------------
  // Alarm and dwell state
  // --------------------------------------------------------------------------
  // The set path wins over a clear in the same cycle so a new crossing is never lost.
  assign alarm_next = !enable ? 1'b0 :
                      set_hit ? 1'b1 :
                      (alarm && below && dwell_done) ? 1'b0 : alarm;
  assign dwell_cnt_next = (!enable || !alarm || !below || set_hit || dwell_done) ?
                          '0 : dwell_cnt_reg + `FDO_DWELL_W'(1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      above_pipe_reg <= '0;
      ovr_pipe_reg <= '0;
      alarm <= 1'b0;
      clip <= 1'b0;
      dwell_cnt_reg <= '0;
    end else begin
      above_pipe_reg <= {above_pipe_reg[UPPER_LAT-3:0], above_now};
      ovr_pipe_reg <= {ovr_pipe_reg[DATA_LAT-3:0], ovr_in};
      alarm <= alarm_next;
      clip <= ovr_pipe_reg[DATA_LAT-2];
      dwell_cnt_reg <= dwell_cnt_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DATA_LAT-1; i++) begin
        mag_pipe_reg[i] <= '0;
      end
    end else begin
      mag_pipe_reg[0] <= mag;
      for (int i = 1; i < DATA_LAT-1; i++) begin
        mag_pipe_reg[i] <= mag_pipe_reg[i-1];
      end
    end
  end

endmodule // fdo_chan_det

`default_nettype wire

// [rtl/fdo_top.sv]
// What this block does
// - When enabled, a channel raises its level alarm once its sample magnitude is above the upper threshold.
// - The alarm drops when its channel is disabled, or after the magnitude stays below the lower threshold for longer than the dwell time.
// - The upper threshold sits in two registers and is compared with the sample magnitude.
// - A crossing of the upper threshold shows on the alarm pin exactly 28 clock cycles later.
// - The lower threshold is a 13-bit magnitude held in two registers.
// - The lower comparison uses full resolution and sees the ordinary data-path latency.
// - The dwell time is 1 to 65535 cycles from two registers, and software keeps it in that range.
// - Each of the two channels has its own detector and its own alarm pin.
// - An input overrange is driven to the clip pins with the same latency as the sample data.
// - Overrange on any of eight virtual converters sets a sticky status bit that stays until cleared.
// - Software sets and then resets a clear bit, and the matching sticky bit is cleared.

`default_nettype none

`include "fdo_map.svh"

module fdo_top
  import fdo_pkg::*;
#(
  parameter int UPPER_LAT = `FDO_UPPER_LAT,
  parameter int DATA_LAT = `FDO_DATA_LAT
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire fdo_byte_t reg_wdata,
  output fdo_byte_t reg_rdata,
  input wire fdo_sample_t sample_chan_a,
  input wire fdo_sample_t sample_chan_b,
  input wire logic input_overrange_chan_a,
  input wire logic input_overrange_chan_b,
  input wire logic [`FDO_NUM_VCONV-1:0] vconv_overrange,
  output logic level_alarm_pin_chan_a,
  output logic level_alarm_pin_chan_b,
  output logic [1:0] clip_indicator_pins
);

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  fdo_byte_t upper_threshold_low_reg;
  logic [`FDO_MAG_W-9:0] upper_threshold_high_reg;
  fdo_byte_t lower_threshold_low_reg;
  logic [`FDO_MAG_W-9:0] lower_threshold_high_reg;
  fdo_byte_t dwell_time_low_reg;
  fdo_byte_t dwell_time_high_reg;
  logic [1:0] level_alarm_control_reg;
  logic [`FDO_NUM_VCONV-1:0] overrange_clear_reg;
  logic [`FDO_NUM_VCONV-1:0] overrange_sticky_status_reg;
  logic [`FDO_NUM_VCONV-1:0] overrange_sticky_status_next;
  fdo_byte_t reg_rdata_next;

  // --------------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------------
  logic wr_upper_lo;
  logic wr_upper_hi;
  logic wr_lower_lo;
  logic wr_lower_hi;
  logic wr_dwell_lo;
  logic wr_dwell_hi;
  logic wr_ctrl;
  logic wr_ovr_clr;

  assign wr_upper_lo = reg_wr && (reg_addr == `FDO_ADDR_UPPER_LO);
  assign wr_upper_hi = reg_wr && (reg_addr == `FDO_ADDR_UPPER_HI);
  assign wr_lower_lo = reg_wr && (reg_addr == `FDO_ADDR_LOWER_LO);
  assign wr_lower_hi = reg_wr && (reg_addr == `FDO_ADDR_LOWER_HI);
  assign wr_dwell_lo = reg_wr && (reg_addr == `FDO_ADDR_DWELL_LO);
  assign wr_dwell_hi = reg_wr && (reg_addr == `FDO_ADDR_DWELL_HI);
  assign wr_ctrl = reg_wr && (reg_addr == `FDO_ADDR_CTRL);
  assign wr_ovr_clr = reg_wr && (reg_addr == `FDO_ADDR_OVR_CLR);

  // --------------------------------------------------------------------------
  // Assembled values
  // --------------------------------------------------------------------------
  fdo_mag_t upper_thr;
  fdo_mag_t lower_thr;
  fdo_dwell_t dwell;
  logic alarm_a;
  logic alarm_b;
  logic clip_a;
  logic clip_b;

  assign upper_thr = {upper_threshold_high_reg, upper_threshold_low_reg};
  assign lower_thr = {lower_threshold_high_reg, lower_threshold_low_reg};
  assign dwell = {dwell_time_high_reg, dwell_time_low_reg};

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      upper_threshold_low_reg <= `FDO_RST_BYTE;
      upper_threshold_high_reg <= '0;
      lower_threshold_low_reg <= `FDO_RST_BYTE;
      lower_threshold_high_reg <= '0;
    end else begin
      if (wr_upper_lo) begin
        upper_threshold_low_reg <= reg_wdata;
      end
      if (wr_upper_hi) begin
        upper_threshold_high_reg <= reg_wdata[`FDO_MAG_W-9:0];
      end
      if (wr_lower_lo) begin
        lower_threshold_low_reg <= reg_wdata;
      end
      if (wr_lower_hi) begin
        lower_threshold_high_reg <= reg_wdata[`FDO_MAG_W-9:0];
      end
    end
  end

  // Dwell resets to one so an enable without setup never asks for a zero-cycle dwell.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dwell_time_low_reg <= `FDO_RST_DWELL_LO;
      dwell_time_high_reg <= `FDO_RST_BYTE;
      level_alarm_control_reg <= '0;
      overrange_clear_reg <= '0;
    end else begin
      if (wr_dwell_lo) begin
        dwell_time_low_reg <= reg_wdata;
      end
      if (wr_dwell_hi) begin
        dwell_time_high_reg <= reg_wdata;
      end
      if (wr_ctrl) begin
        level_alarm_control_reg <= {reg_wdata[`FDO_CTRL_EN_B_BIT],
                                    reg_wdata[`FDO_CTRL_EN_A_BIT]};
      end
      if (wr_ovr_clr) begin
        overrange_clear_reg <= reg_wdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sticky overrange status
  // --------------------------------------------------------------------------
  // A clear bit holds its status bit at zero while it stays set; a new event
  // in that same cycle still wins, but while the clear stays set the bit drops one cycle after the event ends.
  // sticky per converter
  assign overrange_sticky_status_next = vconv_overrange |
                                        (overrange_sticky_status_reg & ~overrange_clear_reg);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overrange_sticky_status_reg <= '0;
    end else begin
      overrange_sticky_status_reg <= overrange_sticky_status_next;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // The control register also shows the live alarm of each channel, so
  // software can poll the detector without watching the pins.
  always_comb begin
    reg_rdata_next = '0;
    if (reg_addr == `FDO_ADDR_UPPER_LO) begin
      reg_rdata_next = upper_threshold_low_reg;
    end else if (reg_addr == `FDO_ADDR_UPPER_HI) begin
      reg_rdata_next = {3'h0, upper_threshold_high_reg};
    end else if (reg_addr == `FDO_ADDR_LOWER_LO) begin
      reg_rdata_next = lower_threshold_low_reg;
    end else if (reg_addr == `FDO_ADDR_LOWER_HI) begin
      reg_rdata_next = {3'h0, lower_threshold_high_reg};
    end else if (reg_addr == `FDO_ADDR_DWELL_LO) begin
      reg_rdata_next = dwell_time_low_reg;
    end else if (reg_addr == `FDO_ADDR_DWELL_HI) begin
      reg_rdata_next = dwell_time_high_reg;
    end else if (reg_addr == `FDO_ADDR_CTRL) begin
      reg_rdata_next[`FDO_CTRL_EN_A_BIT] = level_alarm_control_reg[0];
      reg_rdata_next[`FDO_CTRL_EN_B_BIT] = level_alarm_control_reg[1];
      reg_rdata_next[`FDO_CTRL_ALM_A_BIT] = alarm_a;
      reg_rdata_next[`FDO_CTRL_ALM_B_BIT] = alarm_b;
    end else if (reg_addr == `FDO_ADDR_OVR_CLR) begin
      reg_rdata_next = overrange_clear_reg;
    end else if (reg_addr == `FDO_ADDR_OVR_STAT) begin
      reg_rdata_next = overrange_sticky_status_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= reg_rdata_next;
    end
  end

  // --------------------------------------------------------------------------
  // Per-channel detectors
  // --------------------------------------------------------------------------
  // independent channel detectors
  fdo_chan_det #(
    .UPPER_LAT(UPPER_LAT),
    .DATA_LAT(DATA_LAT)
  ) u_det_a (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(level_alarm_control_reg[0]),
    .sample(sample_chan_a),
    .ovr_in(input_overrange_chan_a),
    .upper_thr(upper_thr),
    .lower_thr(lower_thr),
    .dwell(dwell),
    .alarm(alarm_a),
    .clip(clip_a)
  );

  fdo_chan_det #(
    .UPPER_LAT(UPPER_LAT),
    .DATA_LAT(DATA_LAT)
  ) u_det_b (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(level_alarm_control_reg[1]),
    .sample(sample_chan_b),
    .ovr_in(input_overrange_chan_b),
    .upper_thr(upper_thr),
    .lower_thr(lower_thr),
    .dwell(dwell),
    .alarm(alarm_b),
    .clip(clip_b)
  );

  // The detector outputs are flip-flops already; these are direct pin ties.
  assign level_alarm_pin_chan_a = alarm_a;
  assign level_alarm_pin_chan_b = alarm_b;
  assign clip_indicator_pins = {clip_b, clip_a};

endmodule // fdo_top

`default_nettype wire

// [tb/fdo_agc_model.sv]
`default_nettype none

// ----------------------------------------------------------------------------
// Gain-control partner: trims gain once per rising edge of an alarm pin
// ----------------------------------------------------------------------------
module fdo_agc_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic alarm_a,
  input wire logic alarm_b,
  output logic [7:0] gain_cuts_a,
  output logic [7:0] gain_cuts_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] prev_reg;

  // A held alarm must cost only one gain step, so only edges are counted.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 2'h0;
      gain_cuts_a <= 8'h00;
      gain_cuts_b <= 8'h00;
    end else begin
      prev_reg <= {alarm_b, alarm_a};
      if (alarm_a && !prev_reg[0]) gain_cuts_a <= gain_cuts_a + 8'h01;
      if (alarm_b && !prev_reg[1]) gain_cuts_b <= gain_cuts_b + 8'h01;
    end
  end
endmodule // fdo_agc_model

`default_nettype wire

// [tb/fdo_top_assertions.sv]
`default_nettype none

module fdo_checker
  import fdo_pkg::*;
#(
  parameter int UPPER_LAT = 28,
  parameter int DATA_LAT = 32
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire fdo_byte_t reg_wdata,
  input wire fdo_byte_t reg_rdata,
  input wire fdo_sample_t sample_chan_a,
  input wire fdo_sample_t sample_chan_b,
  input wire logic input_overrange_chan_a,
  input wire logic input_overrange_chan_b,
  input wire logic [7:0] vconv_overrange,
  input wire logic level_alarm_pin_chan_a,
  input wire logic level_alarm_pin_chan_b,
  input wire logic [1:0] clip_indicator_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  fdo_mag_t mag_a;
  fdo_mag_t mag_b;
  fdo_mag_t upper_q;
  fdo_mag_t lower_q;
  logic [1:0] en_q;
  logic [5:0] up_cnt;
  logic warm;
  logic [7:0] clr_q;
  logic [7:0] seen_q;

  // An independent magnitude, so a fault in the shared helper cannot hide itself.
  function automatic fdo_mag_t ref_mag(input fdo_sample_t s);
    if (!s[13]) begin
      return s[12:0];
    end else if (s == 14'h2000) begin
      return 13'h1FFF;
    end else begin
      return 13'(~s + 14'h0001);
    end
  endfunction

  // Deep history checks wait until the pipeline has refilled after reset.
  assign warm = up_cnt > 6'h22;
  assign mag_a = ref_mag(sample_chan_a);
  assign mag_b = ref_mag(sample_chan_b);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      upper_q <= 13'h0000;
      lower_q <= 13'h0000;
      en_q <= 2'h0;
      up_cnt <= 6'h00;
      clr_q <= 8'h00;
      seen_q <= 8'h00;
    end else begin
      if (up_cnt != 6'h3F) up_cnt <= up_cnt + 6'h01;
      if (reg_wr && reg_addr == 12'h562) clr_q <= reg_wdata;
      // A new event beats a clear that is still held in the same cycle.
      seen_q <= vconv_overrange | (seen_q & ~clr_q);
      if (reg_wr && reg_addr == 12'h247) upper_q[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == 12'h248) upper_q[12:8] <= reg_wdata[4:0];
      if (reg_wr && reg_addr == 12'h249) lower_q[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == 12'h24A) lower_q[12:8] <= reg_wdata[4:0];
      if (reg_wr && reg_addr == 12'h559) en_q <= reg_wdata[1:0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_rise_above_upper: assert property (
    $rose(level_alarm_pin_chan_a) && warm |-> $past(mag_a, UPPER_LAT) > upper_q)
    else $error("alarm rose without an upper crossing");
  a_fall_after_dwell: assert property (
    $fell(level_alarm_pin_chan_a) && $past(en_q[0]) && warm |->
      $past(mag_a, DATA_LAT) < lower_q && $past(mag_a, DATA_LAT + 1) < lower_q)
    else $error("alarm fell without a dwell below lower");
  a_disabled_a_quiet: assert property (!en_q[0] |=> !level_alarm_pin_chan_a)
    else $error("disabled channel a alarms");
  a_disabled_b_quiet: assert property (!en_q[1] |=> !level_alarm_pin_chan_b)
    else $error("disabled channel b alarms");
  a_clip_a_latency: assert property (
    warm |-> clip_indicator_pins[0] == $past(input_overrange_chan_a, DATA_LAT))
    else $error("clip a latency wrong");
  a_clip_b_latency: assert property (
    warm |-> clip_indicator_pins[1] == $past(input_overrange_chan_b, DATA_LAT))
    else $error("clip b latency wrong");
  a_upper_high_read: assert property (
    reg_rd && reg_addr == 12'h248 |=> reg_rdata == {3'b000, upper_q[12:8]})
    else $error("upper threshold high byte wrong");
  a_ctrl_read_back: assert property (reg_rd && reg_addr == 12'h559 |=>
    reg_rdata == {2'b00, $past(level_alarm_pin_chan_b), $past(level_alarm_pin_chan_a),
      2'b00, $past(en_q)})
    else $error("control readback wrong");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_rise_b_upper: assert property (
    $rose(level_alarm_pin_chan_b) && warm |-> $past(mag_b, UPPER_LAT) > upper_q)
    else $error("alarm b rose without an upper crossing");
  a_sticky_status_read: assert property (
    reg_rd && reg_addr == 12'h563 |=> reg_rdata == $past(seen_q))
    else $error("sticky status readback wrong");
endmodule // fdo_checker

bind fdo_top fdo_checker #(.UPPER_LAT(UPPER_LAT), .DATA_LAT(DATA_LAT)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_chan_a(sample_chan_a),
  .sample_chan_b(sample_chan_b), .input_overrange_chan_a(input_overrange_chan_a),
  .input_overrange_chan_b(input_overrange_chan_b), .vconv_overrange(vconv_overrange),
  .level_alarm_pin_chan_a(level_alarm_pin_chan_a),
  .level_alarm_pin_chan_b(level_alarm_pin_chan_b),
  .clip_indicator_pins(clip_indicator_pins));

`default_nettype wire

// [tb/test_fdo_top.sv]
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end

module test_fdo_top
  import fdo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, reg_wr, reg_rd, ova, ovb, alm_a, alm_b;
  logic [11:0] reg_addr;
  fdo_byte_t reg_wdata, reg_rdata;
  fdo_sample_t sa, sb;
  logic [7:0] vov, cuts_a, cuts_b;
  logic [1:0] clip;
  int fails, tests_run;
  logic [11:0] addrs [10] = '{12'h247, 12'h248, 12'h249, 12'h24A, 12'h24B, 12'h24C,
    12'h559, 12'h562, 12'h563, 12'h560};

  fdo_top u_dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_chan_a(sa),
    .sample_chan_b(sb), .input_overrange_chan_a(ova), .input_overrange_chan_b(ovb),
    .vconv_overrange(vov), .level_alarm_pin_chan_a(alm_a), .level_alarm_pin_chan_b(alm_b),
    .clip_indicator_pins(clip));
  fdo_agc_model u_agc (.mclk(mclk), .rst_n(rst_n), .alarm_a(alm_a), .alarm_b(alm_b),
    .gain_cuts_a(cuts_a), .gain_cuts_b(cuts_b));

  always #25 mclk = ~mclk;

  // ----------------------------------------------------------------------------
  // Register access and timing helpers
  // ----------------------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input fdo_byte_t d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic chk_rd(input logic [11:0] a, input fdo_byte_t exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge mclk);
    fails++;
    results();
  end

  initial begin
    {mclk, rst_n, reg_wr, reg_rd, ova, ovb} = 6'h00;
    {reg_addr, reg_wdata, sa, sb, vov} = '0;
    fails = 0;
    tests_run = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      chk_rd(addrs[i], (i == 4) ? 8'h01 : 8'h00);
    end
    wr(12'h247, 8'hFF);
    wr(12'h248, 8'hFF);
    chk_rd(12'h248, 8'h1F);
    wr(12'h248, 8'h0F);
    wr(12'h249, 8'h1D);
    wr(12'h24A, 8'hFF);
    chk_rd(12'h24A, 8'h1F);
    wr(12'h24A, 8'h0A);
    wr(12'h24B, 8'h03);
    wr(12'h24D, 8'h55);
    chk_rd(12'h24D, 8'h00);
    chk_rd(12'h24B, 8'h03);
    wr(12'h24C, 8'h01);
    chk_rd(12'h24C, 8'h01);
    wr(12'h24C, 8'h00);
    // Only channel b is on, so the full-scale negative on a must stay silent.
    wr(12'h559, 8'h02);
    @(posedge mclk);
    sa <= 14'h2000;
    sb <= 14'h2000;
    @(posedge mclk);
    sa <= 14'h0B00;
    sb <= 14'h0B00;
    edges(26);
    `CHK(alm_b, 1'b0)
    edges(1);
    `CHK(alm_b, 1'b1)
    `CHK(alm_a, 1'b0)
    chk_rd(12'h559, 8'h22);
    wr(12'h559, 8'h01);
    edges(1);
    `CHK(alm_b, 1'b0)
    // A value equal to the upper threshold must not count as exceeding it.
    @(posedge mclk);
    sa <= 14'h0FFF;
    @(posedge mclk);
    sa <= 14'h3000;
    @(posedge mclk);
    sa <= 14'h0B00;
    edges(26);
    `CHK(alm_a, 1'b0)
    edges(1);
    `CHK(alm_a, 1'b1)
    edges(40);
    `CHK(alm_a, 1'b1)
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      sa <= (i == 3) ? 14'h0A1D : 14'h0000;
    end
    edges(34);
    `CHK(alm_a, 1'b1)
    edges(1);
    `CHK(alm_a, 1'b0)
    @(posedge mclk);
    ova <= 1'b1;
    @(posedge mclk);
    ova <= 1'b0;
    ovb <= 1'b1;
    @(posedge mclk);
    ovb <= 1'b0;
    edges(30);
    `CHK(clip, 2'h1)
    edges(1);
    `CHK(clip, 2'h2)
    @(posedge mclk);
    vov <= 8'h81;
    @(posedge mclk);
    vov <= 8'h00;
    chk_rd(12'h563, 8'h81);
    wr(12'h562, 8'h01);
    wr(12'h562, 8'h00);
    chk_rd(12'h563, 8'h80);
    `CHK(cuts_a, 8'h01)
    `CHK(cuts_b, 8'h01)
    results();
  end
endmodule // test_fdo_top

`default_nettype wire
